// ### rtl/lps_link_power_state_handshake.sv
// link power state sequencer: aspm l0s, ppm l1/l3 and turn-off handshake
// Function
// - l0s entered and left autonomously
// - l0, l1, l3 states; l0 after training
// - l1 only when state d1/d2/d3hot
// - power state shown on two-bit output
// - tx ready low when not d0 and no packet in progress
// - pm packets exchanged to enter l1
// - wake request ignored if pme disabled
// - turn-off message starts l23 ready negotiation
// - power-down request held until acknowledge
// - acknowledge triggers turn-off ack message
// - after ack all interfaces closed
`default_nettype none
module lps_link_power_state_handshake
#(
    parameter bit D1_SUPPORT = 1'b1, // d1 may lead to l1
    parameter bit D2_SUPPORT = 1'b1 // d2 may lead to l1
)
(
    input wire logic clk,
    input wire logic reset_n,
    // link side events, same clock
    input wire logic link_trained, // training finished
    input wire logic link_idle, // no traffic either way
    input wire logic pmcsr_wr, // pulse: config write of power state
    input wire logic [1:0] pmcsr_wr_state, // written power state
    input wire logic pme_enable, // pme generation allowed
    input wire logic turn_off_msg, // pulse: turn-off broadcast seen
    input wire logic pm_dllp_ack, // pulse: partner acked l1 request
    output logic pm_dllp_req, // pulse: send enter-l1 dllp
    output logic pme_msg_req, // pulse: send pme message
    output logic turn_off_ack_msg, // pulse: send turn-off ack
    output logic [2:0] link_state, // current link state code
    output logic layers_off, // layers disabled, power removable
    // user side
    input wire logic user_tx_valid, // user stream valid
    input wire logic user_tx_last, // last beat of packet
    input wire logic user_wake_request, // pin from user logic
    input wire logic user_turnoff_ok, // pin from user logic
    output logic user_tx_ready, // stream accept
    output logic [1:0] power_state, // programmed device state
    output logic power_down_request // turn-off handshake request
);
    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    typedef enum logic [2:0]
    {
        LS_DOWN,
        LS_L0,
        LS_L0S,
        LS_L1_REQ,
        LS_L1,
        LS_TURNOFF,
        LS_L23,
        LS_L3
    } lps_link_t;

    typedef struct packed
    {
        lps_link_t ls; // link sequencer state
        logic [7:0] idle_cnt; // idle cycles toward l0s
        logic [1:0] pwr; // programmed device power state
        logic in_pkt; // a user packet is mid-flight
        logic tx_rdy; // stream ready
        logic dllp_req; // enter-l1 dllp pulse
        logic pme_req; // pme pulse
        logic wake_prev; // wake level last cycle
        logic to_req; // power-down request level
        logic to_ack; // turn-off ack pulse
        logic off; // layers disabled
        logic [2:0] lcode; // link state output
    } lps_state_t;

    lps_state_t st_q;
    lps_state_t st_d;

    logic wake_s; // synchronised wake request
    logic ok_s; // synchronised turn-off acknowledge
    logic l1_allowed; // current power state permits l1

    // -----------------------------------------------------------------
    // pin synchronisers
    // -----------------------------------------------------------------
    lps_sync u_sync_wake
    (
        .clk(clk),
        .reset_n(reset_n),
        .pin_in(user_wake_request),
        .level_out(wake_s)
    );

    lps_sync u_sync_ok
    (
        .clk(clk),
        .reset_n(reset_n),
        .pin_in(user_turnoff_ok),
        .level_out(ok_s)
    );

    // d1/d2 count only where supported
    always_comb
    begin
        unique case (st_q.pwr)
            lps_pkg::PWR_D3H: l1_allowed = 1'b1;
            lps_pkg::PWR_D1: l1_allowed = D1_SUPPORT;
            lps_pkg::PWR_D2: l1_allowed = D2_SUPPORT;
            default: l1_allowed = 1'b0;
        endcase
    end

    // -----------------------------------------------------------------
    // next state
    // -----------------------------------------------------------------
    always_comb
    begin
        st_d = st_q;
        st_d.dllp_req = 1'b0;
        st_d.pme_req = 1'b0;
        st_d.to_ack = 1'b0;
        st_d.wake_prev = wake_s;

        // power state follows config writes of the partner
        if (pmcsr_wr && !st_q.off)
        begin
            st_d.pwr = pmcsr_wr_state;
        end

        // track packet boundaries so a started packet completes
        if (user_tx_valid && st_q.tx_rdy)
        begin
            st_d.in_pkt = !user_tx_last;
        end

        // wake edge raises a pme only when enabled and not in d0
        if (wake_s && !st_q.wake_prev && pme_enable
            && st_q.pwr != lps_pkg::PWR_D0 && !st_q.off)
        begin
            st_d.pme_req = 1'b1;
        end

        unique case (st_q.ls)
            LS_DOWN:
            begin
                // only a trained link reaches l0
                if (link_trained)
                begin
                    st_d.ls = LS_L0;
                end
            end
            LS_L0, LS_L0S:
            begin
                // idle counter drives l0s entry; traffic leaves it
                if (!link_idle)
                begin
                    st_d.idle_cnt = '0;
                    st_d.ls = LS_L0;
                end
                else if (st_q.idle_cnt != lps_pkg::L0S_IDLE_CNT)
                begin
                    st_d.idle_cnt = st_q.idle_cnt + 8'h01;
                end
                else
                begin
                    st_d.ls = LS_L0S;
                end
                if (!link_trained)
                begin
                    st_d.ls = LS_DOWN;
                end
                else if (turn_off_msg)
                begin
                    st_d.ls = LS_TURNOFF;
                    st_d.to_req = 1'b1;
                end
                else if (l1_allowed)
                begin
                    st_d.ls = LS_L1_REQ;
                    st_d.dllp_req = 1'b1;
                end
            end
            LS_L1_REQ:
            begin
                // wait for the partner's answer to the l1 request;
                // a turn-off arriving meanwhile must not be lost
                if (turn_off_msg)
                begin
                    st_d.ls = LS_TURNOFF;
                    st_d.to_req = 1'b1;
                end
                else if (pm_dllp_ack)
                begin
                    st_d.ls = LS_L1;
                end
                else if (!l1_allowed)
                begin
                    st_d.ls = LS_L0;
                end
            end
            LS_L1:
            begin
                // back to d0 retrains to l0; turn-off still honoured
                if (turn_off_msg)
                begin
                    st_d.ls = LS_TURNOFF;
                    st_d.to_req = 1'b1;
                end
                else if (!l1_allowed)
                begin
                    st_d.ls = LS_L0;
                    st_d.idle_cnt = '0;
                end
            end
            LS_TURNOFF:
            begin
                // ack looked at only while the request is up
                if (st_q.to_req && ok_s)
                begin
                    st_d.to_req = 1'b0;
                    st_d.to_ack = 1'b1;
                    st_d.ls = LS_L23;
                end
            end
            LS_L23:
            begin
                // ack sent: shut every layer down
                st_d.off = 1'b1;
                st_d.ls = LS_L3;
            end
            LS_L3:
            begin
                // terminal until reset restores power
                st_d.off = 1'b1;
            end
        endcase

        // stall new packets outside d0; a packet in progress finishes unless turn-off begins
        // the l23 cycle counts as closed too, before off has settled
        st_d.tx_rdy = !st_d.off
            && !(st_d.ls inside {LS_TURNOFF, LS_L23, LS_L3})
            && (st_d.pwr == lps_pkg::PWR_D0 || st_d.in_pkt);

        // link code for the user
        unique case (st_d.ls)
            LS_DOWN: st_d.lcode = lps_pkg::LNK_DOWN;
            LS_L0, LS_L1_REQ, LS_TURNOFF: st_d.lcode = lps_pkg::LNK_L0;
            LS_L0S: st_d.lcode = lps_pkg::LNK_L0S;
            LS_L1: st_d.lcode = lps_pkg::LNK_L1;
            LS_L23: st_d.lcode = lps_pkg::LNK_L23;
            LS_L3: st_d.lcode = lps_pkg::LNK_L3;
        endcase
    end

    // -----------------------------------------------------------------
    // registers
    // -----------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_q <= '{ls: LS_DOWN, pwr: lps_pkg::PWR_RESET, default: '0};
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // outputs straight from flops
    assign user_tx_ready = st_q.tx_rdy;
    assign power_state = st_q.pwr;
    assign power_down_request = st_q.to_req;
    assign pm_dllp_req = st_q.dllp_req;
    assign pme_msg_req = st_q.pme_req;
    assign turn_off_ack_msg = st_q.to_ack;
    assign link_state = st_q.lcode;
    assign layers_off = st_q.off;
endmodule : lps_link_power_state_handshake
`default_nettype wire

// ### rtl/lps_pkg.sv
// constants shared by the link power state handshake block
`default_nettype none
package lps_pkg;
    // -----------------------------------------------------------------
    // device power state codes
    // -----------------------------------------------------------------
    localparam logic [1:0] PWR_D0 = 2'h0; // full power
    localparam logic [1:0] PWR_D1 = 2'h1; // light sleep
    localparam logic [1:0] PWR_D2 = 2'h2; // deeper sleep
    localparam logic [1:0] PWR_D3H = 2'h3; // d3 hot
    localparam logic [1:0] PWR_RESET = 2'h0; // reset value of state
    // -----------------------------------------------------------------
    // link state codes shown to user logic
    // -----------------------------------------------------------------
    localparam logic [2:0] LNK_DOWN = 3'h0; // not trained
    localparam logic [2:0] LNK_L0 = 3'h1; // active
    localparam logic [2:0] LNK_L0S = 3'h2; // aspm standby
    localparam logic [2:0] LNK_L1 = 3'h3; // programmed standby
    localparam logic [2:0] LNK_L23 = 3'h4; // l2/l3 ready
    localparam logic [2:0] LNK_L3 = 3'h5; // link off
    // -----------------------------------------------------------------
    // timing
    // -----------------------------------------------------------------
    localparam int CLK_NS = 40; // 25 MHz clock period
    localparam int L0S_IDLE_NS = 280; // idle time before l0s entry
    localparam int L0S_IDLE_CYC = (L0S_IDLE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0] L0S_IDLE_CNT = 8'(L0S_IDLE_CYC);
endpackage : lps_pkg
`default_nettype wire

// ### rtl/lps_sync.sv
// three-stage synchroniser with agreement filter for one pin
`default_nettype none
module lps_sync
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic pin_in,
    output logic level_out
);
    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    typedef struct packed
    {
        logic s1; // first stage, read only by s2
        logic s2;
        logic s3;
        logic lvl; // filtered level
    } lps_sync_t;
    lps_sync_t st_q;
    lps_sync_t st_d;

    // next state: change only when stages two and three agree
    always_comb
    begin
        st_d = st_q;
        st_d.s1 = pin_in;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        if (st_q.s2 == st_q.s3)
        begin
            st_d.lvl = st_q.s3;
        end
    end

    // registers
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign level_out = st_q.lvl;
endmodule : lps_sync
`default_nettype wire

// ### test/lps_far_model.sv
// far side model: link partner and user turn-off logic
`default_nettype none
module lps_far_model
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic pm_dllp_req,
    input wire logic power_down_request,
    input wire logic stray_ok, // bench-made stray acknowledge
    input wire logic [7:0] ok_wait, // user drain time, slow or prompt
    output logic pm_dllp_ack,
    output logic user_turnoff_ok
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] dly_q; // partner answer pipeline
    int n; // cycles since request seen
    // partner accepts each enter-l1 packet two cycles later
    always_ff @(posedge clk or negedge reset_n)
        if (!reset_n)
            dly_q <= 2'h0;
        else
            dly_q <= {dly_q[0], pm_dllp_req};
    assign pm_dllp_ack = dly_q[1];
    // user drains its packet before it commits to power-down
    always_ff @(posedge clk or negedge reset_n)
        if (!reset_n)
            n <= 0;
        else
            n <= power_down_request ? n + 1 : 0;
    assign user_turnoff_ok = stray_ok
        | (power_down_request && n >= int'(ok_wait));
endmodule : lps_far_model
`default_nettype wire

// ### test/lps_monitor.sv
// assertion checker bound to the link power state handshake block
`default_nettype none
module lps_monitor
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic pmcsr_wr,
    input wire logic [1:0] pmcsr_wr_state,
    input wire logic pme_enable,
    input wire logic turn_off_msg,
    input wire logic pm_dllp_ack,
    input wire logic pm_dllp_req,
    input wire logic pme_msg_req,
    input wire logic turn_off_ack_msg,
    input wire logic [2:0] link_state,
    input wire logic layers_off,
    input wire logic user_tx_valid,
    input wire logic user_tx_last,
    input wire logic user_turnoff_ok,
    input wire logic user_tx_ready,
    input wire logic [1:0] power_state,
    input wire logic power_down_request
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------
    // helper: a user packet taken but not yet ended
    // ------------
    logic pkt_q; // mid-packet, so ready may stay up outside d0
    // follow accepted beats; the last beat closes the packet
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pkt_q <= 1'b0;
        end
        else if (user_tx_valid && user_tx_ready)
        begin
            pkt_q <= !user_tx_last;
        end
    end
    // ------------
    // properties, all on the one clock
    // ------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    pstate_load_a: assert property (
        pmcsr_wr && !layers_off |=> power_state == $past(pmcsr_wr_state))
        else $error("power state not loaded");
    // a packet under way is exempt here; between packets outside d0 ready stalls
    ready_stall_a: assert property (
        power_state != lps_pkg::PWR_D0 && !pkt_q |-> !user_tx_ready)
        else $error("ready high outside d0");
    l1_cause_a: assert property (
        link_state == lps_pkg::LNK_L1 && $past(link_state) != 3'h3
        |-> $past(pm_dllp_ack) && power_state != lps_pkg::PWR_D0)
        else $error("l1 entered without cause");
    l1_request_gate_a: assert property (
        pm_dllp_req |-> $past(power_state) != lps_pkg::PWR_D0)
        else $error("l1 request without low power state");
    // the pulse is launched from the previous cycle's gate values
    wake_gate_a: assert property (
        pme_msg_req |-> $past(pme_enable)
        && $past(power_state) != lps_pkg::PWR_D0)
        else $error("wake message not gated");
    turnoff_start_a: assert property (
        turn_off_msg && !power_down_request
        && link_state inside {3'h1, 3'h2, 3'h3}
        |=> power_down_request && !user_tx_ready)
        else $error("turn-off request not raised");
    // the acknowledge pin crosses a synchroniser, so look three samples back
    req_hold_a: assert property (
        power_down_request && !user_turnoff_ok
        && !$past(user_turnoff_ok) && !$past(user_turnoff_ok, 2)
        && !$past(user_turnoff_ok, 3) |=> power_down_request)
        else $error("request dropped without acknowledge");
    ack_cause_a: assert property (
        $fell(power_down_request) == turn_off_ack_msg)
        else $error("ack message not tied to request end");
    // the ack pulse and the l23 code share a cycle; l3 follows
    off_seq_a: assert property (
        turn_off_ack_msg
        |-> (link_state == lps_pkg::LNK_L23 && !user_tx_ready)
        ##1 (layers_off && link_state == lps_pkg::LNK_L3))
        else $error("shutdown order wrong");
    off_hold_a: assert property (
        layers_off |=> layers_off && link_state == lps_pkg::LNK_L3
        && !user_tx_ready && !power_down_request)
        else $error("interfaces reopened after shutdown");
endmodule : lps_monitor
bind lps_link_power_state_handshake lps_monitor u_mon
(
    .clk(clk), .reset_n(reset_n), .pmcsr_wr(pmcsr_wr),
    .pmcsr_wr_state(pmcsr_wr_state), .pme_enable(pme_enable),
    .turn_off_msg(turn_off_msg), .pm_dllp_ack(pm_dllp_ack),
    .pm_dllp_req(pm_dllp_req), .user_tx_last(user_tx_last),
    .pme_msg_req(pme_msg_req), .turn_off_ack_msg(turn_off_ack_msg),
    .link_state(link_state), .layers_off(layers_off),
    .user_tx_valid(user_tx_valid), .user_turnoff_ok(user_turnoff_ok),
    .user_tx_ready(user_tx_ready), .power_state(power_state),
    .power_down_request(power_down_request)
);
`default_nettype wire

// ### test/testbench.sv
// self-checking bench for the link power state handshake block
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    // ------------
    // signals, rows and counters
    // ------------
    logic clk, reset_n, trained, idle, wr, pme_en, toff, valid, last;
    logic wake, stray, ack, req, pme, to_ack, off, ready, pdr, okp;
    logic [1:0] wr_st, pst;
    logic [2:0] lst;
    logic [7:0] ok_wait;
    int bad_count = 0;
    int comparisons = 0;
    int pme_n = 0;
    int ack_n = 0;
    int dllp_n = 0;
    // written state, expected ready, expected link state
    typedef struct packed {logic [1:0] st; logic rdy; logic [2:0] ls;}
        lps_row_t;
    lps_row_t rows [6] = '{'{2'h3, 1'h0, 3'h3}, '{2'h0, 1'h1, 3'h1},
        '{2'h1, 1'h0, 3'h3}, '{2'h0, 1'h1, 3'h1},
        '{2'h2, 1'h0, 3'h3}, '{2'h0, 1'h1, 3'h1}};
    lps_link_power_state_handshake u_dut
    (
        .clk(clk), .reset_n(reset_n), .link_trained(trained),
        .link_idle(idle), .pmcsr_wr(wr), .pmcsr_wr_state(wr_st),
        .pme_enable(pme_en), .turn_off_msg(toff), .pm_dllp_ack(ack),
        .pm_dllp_req(req), .pme_msg_req(pme), .turn_off_ack_msg(to_ack),
        .link_state(lst), .layers_off(off), .user_tx_valid(valid),
        .user_tx_last(last), .user_wake_request(wake),
        .user_turnoff_ok(okp), .user_tx_ready(ready),
        .power_state(pst), .power_down_request(pdr)
    );
    lps_far_model u_far
    (
        .clk(clk), .reset_n(reset_n), .pm_dllp_req(req),
        .power_down_request(pdr), .stray_ok(stray), .ok_wait(ok_wait),
        .pm_dllp_ack(ack), .user_turnoff_ok(okp)
    );
    // ------------
    // helpers
    // ------------
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // pulses counted mid-cycle, away from the launching edge
    always @(negedge clk)
    begin
        pme_n += int'(pme === 1'b1);
        ack_n += int'(to_ack === 1'b1);
        dllp_n += int'(req === 1'b1);
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : step
    task automatic chk(input logic [2:0] got, input logic [2:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wait_ls(input logic [2:0] s);
        for (int i = 0; i < 40 && lst !== s; i++)
            step(1);
        chk(lst, s);
    endtask : wait_ls
    task automatic wr_state(input logic [1:0] s);
        wr = 1'b1;
        wr_st = s;
        step(1);
        wr = 1'b0;
    endtask : wr_state
    task automatic pulse_wake;
        wake = 1'b1;
        step(10);
        wake = 1'b0;
        step(6);
    endtask : pulse_wake
    task automatic end_of_test;
        $display("mismatches %0d comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_of_test
    // watchdog: the whole run takes well under 500 cycles
    initial
    begin
        #80000;
        bad_count++;
        end_of_test();
    end
    // ------------
    // main sequence
    // ------------
    initial
    begin
        {reset_n, trained, idle, wr, pme_en, toff, valid, last} = '0;
        {wake, stray, wr_st, ok_wait} = {2'h0, 2'h0, 8'h02};
        step(16);
        chk({pst, pdr}, 3'h0);
        reset_n = 1'b1;
        trained = 1'b1;
        wait_ls(lps_pkg::LNK_L0);
        idle = 1'b1;
        step(6);
        chk(lst, lps_pkg::LNK_L0); // too short for standby
        step(4);
        chk(lst, lps_pkg::LNK_L0S);
        idle = 1'b0;
        step(2);
        chk(lst, lps_pkg::LNK_L0);
        foreach (rows[i]) // no packets sent while outside d0
        begin
            wr_state(rows[i].st);
            wait_ls(rows[i].ls);
            chk(3'(pst), 3'(rows[i].st));
            chk(3'(ready), 3'(rows[i].rdy));
        end
        chk(3'(dllp_n), 3'h3); // one enter-l1 packet per entry
        valid = 1'b1; // packet begun in d0
        step(1);
        wr_state(2'h3);
        chk(3'(ready), 3'h1); // pending packet still taken
        last = 1'b1;
        step(1);
        {valid, last} = 2'h0;
        step(1);
        chk(3'(ready), 3'h0);
        pulse_wake();
        chk(3'(pme_n), 3'h0); // pme disabled
        pme_en = 1'b1;
        pulse_wake();
        chk(3'(pme_n), 3'h1);
        wr_state(2'h0);
        wait_ls(lps_pkg::LNK_L0);
        pulse_wake();
        chk(3'(pme_n), 3'h1); // no wake while in d0
        stray = 1'b1;
        step(8);
        stray = 1'b0;
        step(6);
        chk({ack_n[1:0], pdr}, 3'h0);
        ok_wait = 8'h14;
        toff = 1'b1;
        step(1);
        toff = 1'b0;
        step(15);
        chk({pdr, ready, off}, 3'h4); // slow user holds request
        wait_ls(lps_pkg::LNK_L3);
        chk({pdr, off, ack_n[0]}, 3'h3);
        wr_state(2'h3);
        step(1);
        chk(3'(pst), 3'h0); // writes refused after shutdown
        reset_n = 1'b0;
        step(2);
        chk({lst[1:0], off}, 3'h0);
        reset_n = 1'b1;
        wait_ls(lps_pkg::LNK_L0);
        trained = 1'b0;
        step(2);
        chk(lst, lps_pkg::LNK_DOWN); // lost training leaves l0
        trained = 1'b1;
        wait_ls(lps_pkg::LNK_L0);
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
